// ### core/pin_remap_pkg.sv
/*
  Constants for the pin remap, analog select and change-notify block.
  Assumes a single 20 MHz system clock and a byte-wide control write port.
*/
package pin_remap_pkg;
  localparam int NUM_PINS      = 16;   // Remappable pins
  localparam int NUM_CN        = 31;   // Change-notify inputs
  localparam int NUM_AN        = 16;   // Analog-shared pins
  localparam int SEL_W         = 5;    // Map field width
  localparam int NUM_IN_MAP    = 15;   // Remappable peripheral inputs
  localparam int NUM_OUT_SRC   = 12;   // Remappable peripheral outputs

  localparam logic [15:0]      ANALOG_SEL_RESET = 16'h0000;
  localparam logic [15:0]      DIR_RESET        = 16'hFFFF;
  localparam logic [SEL_W-1:0] IN_MAP_RESET     = 5'h1F;
  localparam logic [SEL_W-1:0] OUT_MAP_RESET    = 5'h00;
  localparam logic [SEL_W-1:0] IN_TIED_LOW      = 5'h1F;

  localparam int LOCK_BIT     = 6;
  localparam int ONE_WAY_BIT  = 5;
  localparam logic [7:0] KEY_FIRST  = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;

  // Output selection codes
  localparam logic [SEL_W-1:0] OSEL_NULL   = 5'h00;
  localparam logic [SEL_W-1:0] OSEL_CMP1   = 5'h01;
  localparam logic [SEL_W-1:0] OSEL_CMP2   = 5'h02;
  localparam logic [SEL_W-1:0] OSEL_TX     = 5'h03;
  localparam logic [SEL_W-1:0] OSEL_RTS    = 5'h04;
  localparam logic [SEL_W-1:0] OSEL_SDO    = 5'h07;
  localparam logic [SEL_W-1:0] OSEL_SCK    = 5'h08;
  localparam logic [SEL_W-1:0] OSEL_SS     = 5'h09;
  localparam logic [SEL_W-1:0] OSEL_CMPA   = 5'h12;
  localparam logic [SEL_W-1:0] OSEL_CMPB   = 5'h13;
  localparam logic [SEL_W-1:0] OSEL_CHARGE_TIME_PULSE_OUT  = 5'h1D;
  localparam logic [SEL_W-1:0] OSEL_CMP3   = 5'h1E;

  // Peripheral output source indices (order of PERIPH_OUT bits)
  localparam int SRC_CMP1 = 0;
  localparam int SRC_CMP2 = 1;
  localparam int SRC_TX   = 2;
  localparam int SRC_RTS  = 3;
  localparam int SRC_SDO  = 4;
  localparam int SRC_SCK  = 5;
  localparam int SRC_SS   = 6;
  localparam int SRC_CMPA = 7;
  localparam int SRC_CMPB = 8;
  localparam int SRC_CHARGE_TIME_PULSE_OUT = 9;
  localparam int SRC_CMP3 = 10;
  localparam int SRC_RSVD = 11;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT1 = 2'b01,
    KEY_OPEN = 2'b10
  } key_state_t;
endpackage : pin_remap_pkg

// ### core/map_store.sv
/*
  Mapping register store with a shadow copy and a continuous compare.
  Assumes writes are already qualified by the lock; the shadow is written
  only by the same qualified strobe, so any other difference is a fault.
*/
`timescale 1ns/1ps
module map_store #(
  parameter int ENTRIES = 16,
  parameter int WIDTH   = 5,
  parameter logic [4:0] INIT = 5'h00
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       wr_en,
  input  wire logic [4:0]                 wr_idx,
  input  wire logic [WIDTH-1:0]           wr_data,
  output logic      [ENTRIES*WIDTH-1:0]   fields,
  output logic                            mismatch
);
  logic [WIDTH-1:0] shadow_reg [ENTRIES];
  logic [ENTRIES-1:0] diff;

  // Main copy and shadow copy, one write strobe for both
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          fields[g*WIDTH +: WIDTH] <= INIT[WIDTH-1:0];
        end else if (wr_en && wr_idx == 5'(g)) begin
          fields[g*WIDTH +: WIDTH] <= wr_data;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          shadow_reg[g] <= INIT[WIDTH-1:0];
        end else if (wr_en && wr_idx == 5'(g)) begin
          shadow_reg[g] <= wr_data;
        end
      end
      assign diff[g] = (fields[g*WIDTH +: WIDTH] != shadow_reg[g]);
    end
  endgenerate

  // Registered so a glitch in the compare cannot fire the reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mismatch <= 1'b0;
    end else begin
      mismatch <= |diff;
    end
  end
endmodule : map_store

// ### core/pin_remap_top.sv
/*
  Port pin logic: analog select, change notification with pull-ups,
  remappable input and output multiplexers, and the mapping lock.
  Assumes one 20 MHz clock; control writes arrive as one-cycle strobes
  from the CPU side; pin levels arrive asynchronously from the pads.
*/
`timescale 1ns/1ps
module pin_remap_top
  import pin_remap_pkg::*;
(
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST,
  input  wire logic [NUM_PINS-1:0]         PIN_IN,
  output logic      [NUM_PINS-1:0]         PIN_OUT,
  output logic      [NUM_PINS-1:0]         PIN_OE,
  input  wire logic [NUM_PINS-1:0]         PORT_OUT,
  input  wire logic                        OSC_CTRL_WR,
  input  wire logic [7:0]                  OSC_CTRL_DATA,
  output logic      [7:0]                  OSC_CTRL_RD,
  input  wire logic [7:0]                  OSC_CONFIG_WORD,
  input  wire logic                        IN_MAP_WR,
  input  wire logic [4:0]                  IN_MAP_IDX,
  input  wire logic [SEL_W-1:0]            IN_MAP_DATA,
  output logic      [NUM_IN_MAP*SEL_W-1:0] IN_MAP_FIELDS,
  input  wire logic                        OUT_MAP_WR,
  input  wire logic [4:0]                  OUT_MAP_IDX,
  input  wire logic [SEL_W-1:0]            OUT_MAP_DATA,
  output logic      [NUM_PINS*SEL_W-1:0]   OUT_MAP_FIELDS,
  output logic                             MISMATCH_RESET,
  input  wire logic [NUM_OUT_SRC-1:0]      PERIPH_OUT,
  input  wire logic [NUM_OUT_SRC-1:0]      PERIPH_OE,
  output logic      [NUM_IN_MAP-1:0]       PERIPH_IN,
  input  wire logic                        DIR_WR,
  input  wire logic [15:0]                 DIR_DATA,
  output logic      [15:0]                 PIN_DIRECTION_REG,
  input  wire logic                        ANALOG_WR,
  input  wire logic [15:0]                 ANALOG_DATA,
  output logic      [15:0]                 ANALOG_PIN_SELECT,
  output logic      [15:0]                 PIN_LEVEL_REG,
  input  wire logic [NUM_CN-1:0]           CN_PIN_IN,
  input  wire logic                        CN_EN_A_WR,
  input  wire logic                        CN_EN_B_WR,
  input  wire logic                        PULLUP_A_WR,
  input  wire logic                        PULLUP_B_WR,
  input  wire logic [15:0]                 CN_DATA,
  output logic      [NUM_CN-1:0]           CHANGE_NOTIFY_ENABLE,
  output logic      [NUM_CN-1:0]           WEAK_PULLUP_ENABLE,
  output logic                             CHANGE_NOTIFY_REQ
);
  logic [NUM_PINS-1:0] pin_s1, pin_s2;
  logic [NUM_CN-1:0]   cn_s1, cn_s2, cn_last;
  logic                lock_reg;
  logic                one_way_reg;
  logic                lock_set_once;
  key_state_t          key_reg;
  logic                in_wr_ok, out_wr_ok;
  logic                mis_in, mis_out;
  logic [SEL_W-1:0]    osel [NUM_PINS];
  logic [SEL_W-1:0]    isel [NUM_IN_MAP];
  logic [NUM_PINS:0]   rp_in_ext;
  logic [NUM_CN-1:0]   cn_change;

  // Pad inputs are asynchronous; two flops before any logic
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      cn_s1  <= '0;
      cn_s2  <= '0;
    end else begin
      pin_s1 <= PIN_IN;
      pin_s2 <= pin_s1;
      cn_s1  <= CN_PIN_IN;
      cn_s2  <= cn_s1;
    end
  end

  // Direction register, all inputs out of reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PIN_DIRECTION_REG <= DIR_RESET;
    end else if (DIR_WR) begin
      PIN_DIRECTION_REG <= DIR_DATA;
    end
  end

  // Analog select: zero means analog, so all shared pins start analog
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ANALOG_PIN_SELECT <= ANALOG_SEL_RESET;
    end else if (ANALOG_WR) begin
      ANALOG_PIN_SELECT <= ANALOG_DATA;
    end
  end

  // Pin read path; analog pins read zero here, but the input muxes still see them
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PIN_LEVEL_REG <= '0;
    end else begin
      PIN_LEVEL_REG <= pin_s2 & ANALOG_PIN_SELECT;
    end
  end

  // Strap sampled after reset release, never under the async reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      one_way_reg <= 1'b1;
    end else begin
      one_way_reg <= OSC_CONFIG_WORD[ONE_WAY_BIT];
    end
  end

  // Unlock key tracker: 0x46 then 0x57, next write changes the lock
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      key_reg <= KEY_IDLE;
    end else if (OSC_CTRL_WR) begin
      case (key_reg)
        KEY_IDLE: key_reg <= (OSC_CTRL_DATA == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
        KEY_GOT1: key_reg <= (OSC_CTRL_DATA == KEY_SECOND) ? KEY_OPEN :
                             (OSC_CTRL_DATA == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
        KEY_OPEN: key_reg <= KEY_IDLE;
        default:  key_reg <= KEY_IDLE;
      endcase
    end
  end

  // Lock bit: only the write straight after the keys may change it,
  // and it stays put otherwise; one-way option blocks clearing
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lock_reg      <= 1'b0;
      lock_set_once <= 1'b0;
    end else if (OSC_CTRL_WR && key_reg == KEY_OPEN) begin
      if (OSC_CTRL_DATA[LOCK_BIT]) begin
        lock_reg      <= 1'b1;
        lock_set_once <= 1'b1;
      end else if (!(one_way_reg && lock_set_once)) begin
        lock_reg <= 1'b0;
      end
    end
  end

  assign OSC_CTRL_RD = {1'b0, lock_reg, 6'h00};

  // Locked writes are accepted by the bus but not stored
  assign in_wr_ok  = IN_MAP_WR && !lock_reg && IN_MAP_IDX < 5'(NUM_IN_MAP);
  assign out_wr_ok = OUT_MAP_WR && !lock_reg && OUT_MAP_IDX < 5'(NUM_PINS);

  map_store #(.ENTRIES(NUM_IN_MAP), .WIDTH(SEL_W), .INIT(IN_MAP_RESET)) u_in_map (
    .clk      (CLK_SYS),
    .rst      (RST),
    .wr_en    (in_wr_ok),
    .wr_idx   (IN_MAP_IDX),
    .wr_data  (IN_MAP_DATA),
    .fields   (IN_MAP_FIELDS),
    .mismatch (mis_in)
  );

  map_store #(.ENTRIES(NUM_PINS), .WIDTH(SEL_W), .INIT(OUT_MAP_RESET)) u_out_map (
    .clk      (CLK_SYS),
    .rst      (RST),
    .wr_en    (out_wr_ok),
    .wr_idx   (OUT_MAP_IDX),
    .wr_data  (OUT_MAP_DATA),
    .fields   (OUT_MAP_FIELDS),
    .mismatch (mis_out)
  );

  // Any shadow difference requests the configuration mismatch reset
  assign MISMATCH_RESET = mis_in | mis_out;

  // Input muxes per peripheral; out-of-range codes tie the input low
  assign rp_in_ext = {1'b0, pin_s2};
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN_MAP; gi++) begin : g_in
      assign isel[gi] = IN_MAP_FIELDS[gi*SEL_W +: SEL_W];
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          PERIPH_IN[gi] <= 1'b0;
        end else if (isel[gi] < 5'(NUM_PINS)) begin
          PERIPH_IN[gi] <= rp_in_ext[isel[gi]];
        end else begin
          PERIPH_IN[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Output muxes per pin; code zero and unknown codes give the port back
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_out
      assign osel[gp] = OUT_MAP_FIELDS[gp*SEL_W +: SEL_W];
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          PIN_OUT[gp] <= 1'b0;
          PIN_OE[gp]  <= 1'b0;
        end else begin
          case (osel[gp])
            OSEL_CMP1: begin PIN_OUT[gp] <= PERIPH_OUT[SRC_CMP1]; PIN_OE[gp] <= PERIPH_OE[SRC_CMP1]; end
            OSEL_CMP2: begin PIN_OUT[gp] <= PERIPH_OUT[SRC_CMP2]; PIN_OE[gp] <= PERIPH_OE[SRC_CMP2]; end
            OSEL_CMP3: begin PIN_OUT[gp] <= PERIPH_OUT[SRC_CMP3]; PIN_OE[gp] <= PERIPH_OE[SRC_CMP3]; end
            OSEL_TX:   begin PIN_OUT[gp] <= PERIPH_OUT[SRC_TX];   PIN_OE[gp] <= PERIPH_OE[SRC_TX];   end
            OSEL_RTS:  begin PIN_OUT[gp] <= PERIPH_OUT[SRC_RTS];  PIN_OE[gp] <= PERIPH_OE[SRC_RTS];  end
            OSEL_SDO:  begin PIN_OUT[gp] <= PERIPH_OUT[SRC_SDO];  PIN_OE[gp] <= PERIPH_OE[SRC_SDO];  end
            OSEL_SCK:  begin PIN_OUT[gp] <= PERIPH_OUT[SRC_SCK];  PIN_OE[gp] <= PERIPH_OE[SRC_SCK];  end
            OSEL_SS:   begin PIN_OUT[gp] <= PERIPH_OUT[SRC_SS];   PIN_OE[gp] <= PERIPH_OE[SRC_SS];   end
            OSEL_CMPA: begin PIN_OUT[gp] <= PERIPH_OUT[SRC_CMPA]; PIN_OE[gp] <= PERIPH_OE[SRC_CMPA]; end
            OSEL_CMPB: begin PIN_OUT[gp] <= PERIPH_OUT[SRC_CMPB]; PIN_OE[gp] <= PERIPH_OE[SRC_CMPB]; end
            OSEL_CHARGE_TIME_PULSE_OUT: begin PIN_OUT[gp] <= PERIPH_OUT[SRC_CHARGE_TIME_PULSE_OUT]; PIN_OE[gp] <= PERIPH_OE[SRC_CHARGE_TIME_PULSE_OUT]; end
            default: begin
              // Default port owns the pin; direction zero drives it
              PIN_OUT[gp] <= PORT_OUT[gp];
              PIN_OE[gp]  <= ~PIN_DIRECTION_REG[gp];
            end
          endcase
        end
      end
    end
  endgenerate

  // Change-notify enables and pull-ups: low half in A, upper bits in B
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CHANGE_NOTIFY_ENABLE <= '0;
    end else begin
      if (CN_EN_A_WR) CHANGE_NOTIFY_ENABLE[15:0]  <= CN_DATA;
      if (CN_EN_B_WR) CHANGE_NOTIFY_ENABLE[30:16] <= CN_DATA[14:0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WEAK_PULLUP_ENABLE <= '0;
    end else begin
      if (PULLUP_A_WR) WEAK_PULLUP_ENABLE[15:0]  <= CN_DATA;
      if (PULLUP_B_WR) WEAK_PULLUP_ENABLE[30:16] <= CN_DATA[14:0];
    end
  end

  // Change detect; in Sleep the synchroniser needs the clock, so wake
  // logic outside must restart it. Limitation traded for one domain.
  assign cn_change = (cn_s2 ^ cn_last) & CHANGE_NOTIFY_ENABLE;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cn_last           <= '0;
      CHANGE_NOTIFY_REQ <= 1'b0;
    end else begin
      cn_last           <= cn_s2;
      CHANGE_NOTIFY_REQ <= |cn_change;
    end
  end

  a_locked_in_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    (lock_reg && !MISMATCH_RESET) |=> $stable(IN_MAP_FIELDS))
    else $error("input map changed while locked");
  a_locked_out_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    (lock_reg && !MISMATCH_RESET) |=> $stable(OUT_MAP_FIELDS))
    else $error("output map changed while locked");
  a_analog_reads_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((PIN_LEVEL_REG & ~ANALOG_PIN_SELECT) == 16'h0000 || $changed(ANALOG_PIN_SELECT)))
    else $error("analog pin read nonzero");
  a_lock_needs_key: assert property (@(posedge CLK_SYS) disable iff (RST)
    $changed(lock_reg) |-> $past(key_reg) == KEY_OPEN && $past(OSC_CTRL_WR))
    else $error("lock changed without key");
  a_one_way_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    (lock_reg && lock_set_once && one_way_reg) |=> lock_reg)
    else $error("lock cleared under one-way option");
  a_cn_request: assert property (@(posedge CLK_SYS) disable iff (RST)
    (|((cn_s2 ^ cn_last) & CHANGE_NOTIFY_ENABLE)) |=> CHANGE_NOTIFY_REQ)
    else $error("enabled change missed");
  a_cn_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
    (CHANGE_NOTIFY_ENABLE == '0 && $past(CHANGE_NOTIFY_ENABLE) == '0) |-> !CHANGE_NOTIFY_REQ)
    else $error("request with all enables off");
  a_null_default: assert property (@(posedge CLK_SYS) disable iff (RST)
    (osel[0] == OSEL_NULL) |=> PIN_OE[0] == ~$past(PIN_DIRECTION_REG[0]))
    else $error("null code not port owned");
  a_tx_route: assert property (@(posedge CLK_SYS) disable iff (RST)
    (osel[1] == OSEL_TX) |=> PIN_OUT[1] == $past(PERIPH_OUT[SRC_TX]))
    else $error("transmit not routed");
endmodule : pin_remap_top

// ### testbench/periph_pad_model.sv
/*
  Pad-side model of the remappable pins and the change-notify lines.
  Assumes the pads settle within one clock; external drivers let go of a
  remappable pin while the block enables its output driver.
*/
`timescale 1ns/1ps
module periph_pad_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [30:0] pullup_en,
  input  wire logic [15:0] ext_level,
  input  wire logic [30:0] ext_cn,
  input  wire logic [30:0] ext_cn_drv,
  output logic      [15:0] pin_in,
  output logic      [30:0] cn_pin_in
);
  // Driven pads loop back; others show the external level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  // An undriven line floats to the pull-up when enabled, else a board pull-down
  assign cn_pin_in = (ext_cn_drv & ext_cn) | (~ext_cn_drv & pullup_en);
endmodule : periph_pad_model

// ### testbench/testbench.sv
/*
  Self-checking bench for the pin remap block: reset values, analog masking,
  output and input maps, the lock and change notification.
  Assumes the pad model above and a 20 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import pin_remap_pkg::*;
  logic CLK_SYS, RST, OSC_CTRL_WR, IN_MAP_WR, OUT_MAP_WR, DIR_WR, ANALOG_WR;
  logic CN_EN_A_WR, CN_EN_B_WR, PULLUP_A_WR, PULLUP_B_WR, MISMATCH_RESET, CHANGE_NOTIFY_REQ;
  logic [15:0] PIN_IN, PIN_OUT, PIN_OE, PORT_OUT, DIR_DATA, PIN_DIRECTION_REG, ANALOG_DATA;
  logic [15:0] ANALOG_PIN_SELECT, PIN_LEVEL_REG, CN_DATA, ext_level, dirv, a, b;
  logic [7:0]  OSC_CTRL_DATA, OSC_CTRL_RD, OSC_CONFIG_WORD;
  logic [4:0]  IN_MAP_IDX, IN_MAP_DATA, OUT_MAP_IDX, OUT_MAP_DATA, sel [15];
  logic [74:0] IN_MAP_FIELDS;
  logic [79:0] OUT_MAP_FIELDS;
  logic [11:0] PERIPH_OUT, PERIPH_OE;
  logic [14:0] PERIPH_IN;
  logic [30:0] CN_PIN_IN, CHANGE_NOTIFY_ENABLE, WEAK_PULLUP_ENABLE, ext_cn, ext_cn_drv, en_exp;
  logic        mm_seen;
  int          err_total, compares, cycles, n, p, j;
  logic [4:0]  codes [13] = '{5'h00, 5'h01, 5'h02, 5'h1E, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09,
                              5'h12, 5'h13, 5'h1D, 5'h05};
  int          srcs [13] = '{-1, 0, 1, 10, 2, 3, 4, 5, 6, 7, 8, 9, -1};

  pin_remap_top i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .PORT_OUT(PORT_OUT), .OSC_CTRL_WR(OSC_CTRL_WR),
    .OSC_CTRL_DATA(OSC_CTRL_DATA), .OSC_CTRL_RD(OSC_CTRL_RD), .OSC_CONFIG_WORD(OSC_CONFIG_WORD),
    .IN_MAP_WR(IN_MAP_WR), .IN_MAP_IDX(IN_MAP_IDX), .IN_MAP_DATA(IN_MAP_DATA),
    .IN_MAP_FIELDS(IN_MAP_FIELDS), .OUT_MAP_WR(OUT_MAP_WR), .OUT_MAP_IDX(OUT_MAP_IDX),
    .OUT_MAP_DATA(OUT_MAP_DATA), .OUT_MAP_FIELDS(OUT_MAP_FIELDS),
    .MISMATCH_RESET(MISMATCH_RESET), .PERIPH_OUT(PERIPH_OUT), .PERIPH_OE(PERIPH_OE),
    .PERIPH_IN(PERIPH_IN), .DIR_WR(DIR_WR), .DIR_DATA(DIR_DATA),
    .PIN_DIRECTION_REG(PIN_DIRECTION_REG), .ANALOG_WR(ANALOG_WR), .ANALOG_DATA(ANALOG_DATA),
    .ANALOG_PIN_SELECT(ANALOG_PIN_SELECT), .PIN_LEVEL_REG(PIN_LEVEL_REG), .CN_PIN_IN(CN_PIN_IN),
    .CN_EN_A_WR(CN_EN_A_WR), .CN_EN_B_WR(CN_EN_B_WR), .PULLUP_A_WR(PULLUP_A_WR),
    .PULLUP_B_WR(PULLUP_B_WR), .CN_DATA(CN_DATA), .CHANGE_NOTIFY_ENABLE(CHANGE_NOTIFY_ENABLE),
    .WEAK_PULLUP_ENABLE(WEAK_PULLUP_ENABLE), .CHANGE_NOTIFY_REQ(CHANGE_NOTIFY_REQ));

  periph_pad_model i_pads (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .pullup_en(WEAK_PULLUP_ENABLE),
    .ext_level(ext_level), .ext_cn(ext_cn), .ext_cn_drv(ext_cn_drv), .pin_in(PIN_IN),
    .cn_pin_in(CN_PIN_IN));

  // Clock: 50 ns period
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  // Hang guard and mismatch-reset watch
  always @(posedge CLK_SYS) begin
    cycles++;
    if (!RST && MISMATCH_RESET !== 1'b0) mm_seen = 1'b1;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report();
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Inputs change a fixed 5 ns after the rising edge
  task automatic tick();
    @(posedge CLK_SYS);
    #5;
  endtask : tick

  task automatic chk(input string name, input logic [79:0] exp, input logic [79:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask : chk

  // Three back-to-back oscillator control writes, strobe held throughout
  task automatic lock_seq(input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] d3);
    OSC_CTRL_WR = 1'b1;
    OSC_CTRL_DATA = d1;
    tick();
    OSC_CTRL_DATA = d2;
    tick();
    OSC_CTRL_DATA = d3;
    tick();
    OSC_CTRL_WR = 1'b0;
    tick();
  endtask : lock_seq

  task automatic map_wr(input logic out, input logic [4:0] idx, input logic [4:0] d);
    {OUT_MAP_IDX, OUT_MAP_DATA, IN_MAP_IDX, IN_MAP_DATA} = {idx, d, idx, d};
    if (out) OUT_MAP_WR = 1'b1;
    else IN_MAP_WR = 1'b1;
    tick();
    {OUT_MAP_WR, IN_MAP_WR} = 2'b00;
    tick();
  endtask : map_wr

  // Which: 0 direction, 1 analog, 2/3 change enable, 4/5 pull-up
  task automatic wr16(input int which, input logic [15:0] d);
    {CN_DATA, DIR_DATA, ANALOG_DATA} = {d, d, d};
    {DIR_WR, ANALOG_WR, CN_EN_A_WR, CN_EN_B_WR, PULLUP_A_WR, PULLUP_B_WR} = 6'b100000 >> which;
    tick();
    {DIR_WR, ANALOG_WR, CN_EN_A_WR, CN_EN_B_WR, PULLUP_A_WR, PULLUP_B_WR} = 6'b000000;
    tick();
  endtask : wr16

  function automatic logic [1:0] exp_out(input int i, input int pin);
    if (srcs[i] < 0) return {~dirv[pin], PORT_OUT[pin]};
    return {PERIPH_OE[srcs[i]], PERIPH_OUT[srcs[i]]};
  endfunction : exp_out

  function automatic logic exp_in(input logic [4:0] s);
    return (s < 5'h10) ? ext_level[s[3:0]] : 1'b0;
  endfunction : exp_in

  initial begin
    {RST, OSC_CTRL_WR, IN_MAP_WR, OUT_MAP_WR, DIR_WR, ANALOG_WR} = 6'b100000;
    {CN_EN_A_WR, CN_EN_B_WR, PULLUP_A_WR, PULLUP_B_WR, mm_seen} = 5'b00000;
    {PORT_OUT, DIR_DATA, ANALOG_DATA, CN_DATA, OSC_CTRL_DATA} = '0;
    {IN_MAP_IDX, IN_MAP_DATA, OUT_MAP_IDX, OUT_MAP_DATA, PERIPH_OUT, PERIPH_OE} = '0;
    {err_total, compares, cycles} = '0;
    OSC_CONFIG_WORD = 8'h20;
    ext_cn_drv = '1;
    ext_cn = '0;
    n = $urandom(32'h14449282);
    ext_level = 16'($urandom);
    repeat (20) tick();
    RST = 1'b0;
    repeat (4) tick();
    // Reset state, then analog pins read low
    chk("ANALOG_PIN_SELECT", 80'h0000, 80'(ANALOG_PIN_SELECT));
    chk("PIN_DIRECTION_REG", 80'hFFFF, 80'(PIN_DIRECTION_REG));
    chk("OSC_CTRL_RD", 80'h00, 80'(OSC_CTRL_RD));
    chk("IN_MAP_FIELDS", 80'({75{1'b1}}), 80'(IN_MAP_FIELDS));
    chk("PIN_LEVEL_REG", 80'h0000, 80'(PIN_LEVEL_REG));
    a = 16'($urandom);
    wr16(1, a);
    repeat (4) tick();
    chk("PIN_LEVEL_REG", 80'(ext_level & a), 80'(PIN_LEVEL_REG));
    // Every output code on a random pin, default code and an unlisted one
    dirv = 16'($urandom);
    wr16(0, dirv);
    {PORT_OUT, PERIPH_OUT, PERIPH_OE} = {16'($urandom), 12'($urandom), 12'($urandom)};
    for (int i = 0; i < 13; i++) begin
      // Transmit code always lands on pin 1 so the routing assertion is exercised
      p = (i == 4) ? 1 : $urandom_range(15, 0);
      map_wr(1'b1, 5'(p), codes[i]);
      tick();
      chk("OUT_MAP_FIELDS", 80'(codes[i]), 80'(OUT_MAP_FIELDS[5*p +: 5]));
      chk("PIN_OE_OUT", 80'(exp_out(i, p)), 80'({PIN_OE[p], PIN_OUT[p]}));
      map_wr(1'b1, 5'(p), 5'h00);
    end
    // Input maps with all pins digital inputs; last one tied low
    wr16(0, 16'hFFFF);
    wr16(1, 16'hFFFF);
    for (int k = 0; k < 15; k++) begin
      sel[k] = (k == 14) ? 5'h1F : 5'($urandom_range(15, 0));
      map_wr(1'b0, 5'(k), sel[k]);
    end
    repeat (4) tick();
    for (int k = 0; k < 15; k++) begin
      chk("IN_MAP_FIELDS", 80'(sel[k]), 80'(IN_MAP_FIELDS[5*k +: 5]));
      chk("PERIPH_IN", 80'(exp_in(sel[k])), 80'(PERIPH_IN[k]));
    end
    // Lock set, writes refused, one-way clear refused, then cleared
    lock_seq(8'h46, 8'h57, 8'h40);
    chk("OSC_CTRL_RD", 80'h40, 80'(OSC_CTRL_RD));
    map_wr(1'b1, 5'h00, 5'h03);
    map_wr(1'b0, 5'h00, 5'h0A);
    chk("OUT_MAP_FIELDS", 80'h00, 80'(OUT_MAP_FIELDS[4:0]));
    chk("IN_MAP_FIELDS", 80'(sel[0]), 80'(IN_MAP_FIELDS[4:0]));
    lock_seq(8'h46, 8'h57, 8'h00);
    chk("OSC_CTRL_RD", 80'h40, 80'(OSC_CTRL_RD));
    OSC_CONFIG_WORD = 8'h00;
    lock_seq(8'h46, 8'h57, 8'h00);
    chk("OSC_CTRL_RD", 80'h00, 80'(OSC_CTRL_RD));
    // Broken key: the third write must not relock
    lock_seq(8'h46, 8'h11, 8'h40);
    repeat (20) tick();
    chk("OSC_CTRL_RD", 80'h00, 80'(OSC_CTRL_RD));
    // Change enables, pull-ups and requests on enabled and disabled lines
    {a, b} = {16'($urandom), 16'($urandom)};
    wr16(2, a);
    wr16(3, b);
    en_exp = {b[14:0], a};
    chk("CHANGE_NOTIFY_ENABLE", 80'(en_exp), 80'(CHANGE_NOTIFY_ENABLE));
    wr16(4, b);
    wr16(5, a);
    chk("WEAK_PULLUP_ENABLE", 80'({a[14:0], b}), 80'(WEAK_PULLUP_ENABLE));
    for (int t = 0; t < 10; t++) begin
      j = (t == 0) ? 0 : (t == 1) ? 30 : $urandom_range(30, 0);
      ext_cn[j] = ~ext_cn[j];
      n = 0;
      repeat (8) begin
        tick();
        if (CHANGE_NOTIFY_REQ === 1'b1) n++;
      end
      chk("CHANGE_NOTIFY_REQ", 80'(en_exp[j]), 80'(n));
    end
    chk("MISMATCH_RESET", 80'h0, 80'(mm_seen));
    final_report();
  end
endmodule : testbench
